// ==== core/short_latch_top.sv ====
// short_latch_top: switch short detection, latch-off and current limits
// assumes sense voltages arrive as mV words from off-domain converters
//
// Overview of operation
// - sample switch drop only after blanking
// - two comparators each step own counter
// - seven events latch the charger off
// - only adapter reconnect clears latch, counters
// - low side trips on phase to ground
// - high side uses adapter_sense_pos minus phase
// - option bit 7 picks 135 or 230 mV
// - option bit 8 enables 750 mV high check
// - non-sync mode keeps bottom gate off
// - non-sync limit 0.25A, 0.5A below 2.5V
// - at input limit, cut charge current
`timescale 1ns/100ps
module short_latch_top (
  input wire logic clk, // 10 MHz core clock
  input wire logic arst_n, // async reset, active low
  input wire logic ce, // clock enable
  input wire logic [short_prot_pkg::option_width-1:0]
    charger_option_word, // host option word
  input wire logic high_edge, // high-side switch turned on, pulse
  input wire logic low_edge, // low-side switch turned on, pulse
  input wire logic [short_prot_pkg::mv_width-1:0]
    adapter_sense_pos, // adapter sense plus, mV
  input wire logic [short_prot_pkg::mv_width-1:0]
    phase_mv, // switching node signed-free drop, mV
  input wire logic phase_neg, // switching node below ground
  input wire logic adapter_present, // adapter detect pin
  input wire logic nonsync_mode, // converter in non-sync mode
  input wire logic [short_prot_pkg::mv_width-1:0]
    batt_mv, // battery voltage, mV
  input wire logic input_at_limit, // input_power_limit reached
  input wire logic [short_prot_pkg::mv_width-1:0]
    charge_req_ma, // requested charge current, mA
  input wire logic low_gate_req, // pwm bottom gate request
  output logic switching_en, // converter may switch
  output logic low_gate, // bottom gate drive
  output logic [short_prot_pkg::mv_width-1:0]
    charge_lim_ma, // granted charge current, mA
  output logic latched_off // latch-off status
);
  import short_prot_pkg::*;
  short_sense_if high_ch ();
  short_sense_if low_ch ();
  // pin synchronisers: two flops on adapter_present, phase_neg and input_at_limit
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic [2:0] sync_next;
  always_comb begin
    sync_next = {adapter_present, phase_neg, input_at_limit};
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
    end else if (ce) begin
      sync1_reg <= sync_next;
      sync2_reg <= sync1_reg;
    end
  end
  logic adapter_s, phase_neg_s, at_limit_s;
  assign {adapter_s, phase_neg_s, at_limit_s} = sync2_reg;
  // adapter sense and phase mv words pass two flops as well; batt_mv does not
  logic [11:0] acp1_reg, acp2_reg, ph1_reg, ph2_reg;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      acp1_reg <= 12'h000;
      acp2_reg <= 12'h000;
      ph1_reg <= 12'h000;
      ph2_reg <= 12'h000;
    end else if (ce) begin
      acp1_reg <= adapter_sense_pos;
      acp2_reg <= acp1_reg;
      ph1_reg <= phase_mv;
      ph2_reg <= ph1_reg;
    end
  end
  // blanking timers, one per switch, started at its turn-on edge
  logic [3:0] hblank_reg, hblank_next, lblank_reg, lblank_next;
  logic hsample_reg, hsample_next, lsample_reg, lsample_next;
  always_comb begin
    hblank_next = hblank_reg;
    lblank_next = lblank_reg;
    hsample_next = 1'b0;
    lsample_next = 1'b0;
    if (high_edge) begin
      hblank_next = blank_cycles;
    end else if (hblank_reg != blank_zero) begin
      hblank_next = hblank_reg - 4'h1;
      hsample_next = (hblank_reg == 4'h1);
    end
    if (low_edge) begin
      lblank_next = blank_cycles;
    end else if (lblank_reg != blank_zero) begin
      lblank_next = lblank_reg - 4'h1;
      lsample_next = (lblank_reg == 4'h1);
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hblank_reg <= blank_zero;
      lblank_reg <= blank_zero;
      hsample_reg <= 1'b0;
      lsample_reg <= 1'b0;
    end else if (ce) begin
      hblank_reg <= hblank_next;
      lblank_reg <= lblank_next;
      hsample_reg <= hsample_next;
      lsample_reg <= lsample_next;
    end
  end
  // comparators
  logic high_en, low_sel;
  logic [11:0] low_thr, high_drop;
  assign high_en = charger_option_word[high_enable_bit];
  assign low_sel = charger_option_word[low_thr_sel_bit];
  assign low_thr = low_sel ? low_thr_hi_mv : low_thr_lo_mv;
  assign high_drop = (acp2_reg > ph2_reg) ?
    acp2_reg - ph2_reg : 12'h000;
  logic state_run;
  // low side: drain-to-source current lifts phase above ground;
  // normal freewheeling pulls phase below ground and never trips
  assign low_ch.trip = state_run && lsample_reg && !phase_neg_s
    && ph2_reg >= low_thr;
  assign high_ch.trip = state_run && hsample_reg && high_en
    && high_drop >= high_thr_mv;
  // adapter reconnect pulse
  logic adapter_d_reg;
  logic reconnect;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      adapter_d_reg <= 1'b0;
    end else if (ce) begin
      adapter_d_reg <= adapter_s;
    end
  end
  assign reconnect = adapter_s && !adapter_d_reg;
  assign high_ch.clear = reconnect;
  assign low_ch.clear = reconnect;
  short_event_counter high_cnt (
    .clk(clk), .arst_n(arst_n), .ce(ce), .sense(high_ch.counter));
  short_event_counter low_cnt (
    .clk(clk), .arst_n(arst_n), .ce(ce), .sense(low_ch.counter));
  // latch-off state
  prot_state_type state_reg, state_next;
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      run_st: begin
        if (!reconnect && (high_ch.reached || low_ch.reached)) begin
          state_next = latched_st;
        end
      end
      latched_st: begin
        if (reconnect) begin
          state_next = run_st;
        end
      end
      default: state_next = latched_st;
    endcase
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= run_st;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end
  assign state_run = (state_reg == run_st);
  // gate and current limit outputs, registered
  logic low_gate_next;
  logic [11:0] lim_next;
  always_comb begin
    low_gate_next = state_run && low_gate_req && !nonsync_mode;
    lim_next = charge_req_ma;
    if (nonsync_mode) begin
      lim_next = (batt_mv < low_batt_mv) ?
        nonsync_low_batt_lim_ma : nonsync_lim_ma;
      if (charge_req_ma < lim_next) begin
        lim_next = charge_req_ma;
      end
    end
    if (at_limit_s && charge_lim_ma != 12'h000
        && charge_lim_ma <= lim_next) begin
      lim_next = charge_lim_ma - 12'h001;
    end
    if (!state_run) begin
      lim_next = 12'h000;
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      low_gate <= 1'b0;
      charge_lim_ma <= 12'h000;
    end else if (ce) begin
      low_gate <= low_gate_next;
      charge_lim_ma <= lim_next;
    end
  end
  assign switching_en = state_run;
  assign latched_off = !state_run;
  latch_on_limit_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    ce && state_run && !reconnect && (high_ch.reached || low_ch.reached)
    |=> latched_off)
    else $error("no latch-off at event limit");
  latch_holds_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    ce && latched_off && !reconnect |=> latched_off)
    else $error("latch cleared without reconnect");
  nonsync_gate_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    ce && nonsync_mode |=> !low_gate)
    else $error("bottom gate on in non-sync mode");
  high_disabled_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    !high_en |-> !high_ch.trip)
    else $error("disabled high comparator tripped");
  blank_sample_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    ce && low_edge ##1 (ce && !low_edge)[*2] |-> lsample_next)
    else $error("sample not after blanking");
  nonsync_limit_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    ce && nonsync_mode && state_run |=>
    charge_lim_ma <= nonsync_low_batt_lim_ma)
    else $error("non-sync limit exceeded");
  low_thr_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    low_ch.trip |-> ph2_reg >= (low_sel ? low_thr_hi_mv : low_thr_lo_mv))
    else $error("low trip below threshold");
  low_dir_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    low_ch.trip |-> !phase_neg_s && lsample_reg)
    else $error("low trip without drain-source flow");
endmodule // short_latch_top

// ==== pkg/short_prot_pkg.sv ====
// short_prot_pkg: constants and types for the switch short latch block
// assumes a 10 MHz core clock and digitised sense voltages in millivolts
package short_prot_pkg;
  localparam int mv_width = 12;
  localparam int option_width = 16;
  localparam int count_width = 3;
  // option word field positions
  localparam int low_thr_sel_bit = 7;
  localparam int high_enable_bit = 8;
  // thresholds in millivolts
  localparam logic [11:0] low_thr_lo_mv = 12'h0087; // 135 mV
  localparam logic [11:0] low_thr_hi_mv = 12'h00e6; // 230 mV
  localparam logic [11:0] high_thr_mv = 12'h02ee; // 750 mV
  // non-synchronous charge current limits in milliamps
  localparam logic [11:0] nonsync_lim_ma = 12'h00fa; // 0.25 A
  localparam logic [11:0] nonsync_low_batt_lim_ma = 12'h01f4; // 0.5 A
  localparam logic [11:0] low_batt_mv = 12'h09c4; // 2.5 V
  // short events before latch-off
  localparam logic [2:0] short_limit = 3'h7;
  localparam logic [2:0] count_zero = 3'h0;
  localparam logic [2:0] count_one = 3'h1;
  // blanking time after each switch edge
  localparam int blank_ns = 200;
  localparam int clk_period_ns = 100;
  localparam int blank_cycles_int =
    (blank_ns + clk_period_ns - 1) / clk_period_ns;
  localparam logic [3:0] blank_cycles = 4'(blank_cycles_int);
  localparam logic [3:0] blank_zero = 4'h0;
  typedef enum logic [1:0] {
    run_st = 2'b01,
    latched_st = 2'b10
  } prot_state_type;
endpackage

// ==== pkg/short_sense_if.sv ====
// short_sense_if: one comparator channel between top and counter
// assumes a single clock domain shared by both ends
`timescale 1ns/100ps
interface short_sense_if;
  logic trip; // comparator trip, one cycle
  logic clear; // counter clear
  logic [2:0] count; // events counted
  logic reached; // count at limit
  modport owner (output trip, output clear, input count, input reached);
  modport counter (input trip, input clear, output count, output reached);
endinterface // short_sense_if

// ==== core/short_event_counter.sv ====
// short_event_counter: saturating count of comparator trips
// assumes trips are already qualified by blanking and enable
`timescale 1ns/100ps
module short_event_counter (
  input wire logic clk, // core clock
  input wire logic arst_n, // async reset, active low
  input wire logic ce, // clock enable
  short_sense_if.counter sense // trip and count channel
);
  import short_prot_pkg::*;
  logic [2:0] count_reg;
  logic [2:0] count_next;
  // next count: clear beats a trip in the same cycle; saturate at limit
  always_comb begin
    count_next = count_reg;
    if (sense.clear) begin
      count_next = count_zero;
    end else if (sense.trip && count_reg != short_limit) begin
      count_next = count_reg + count_one;
    end
  end
  // register count
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count_reg <= count_zero;
    end else if (ce) begin
      count_reg <= count_next;
    end
  end
  assign sense.count = count_reg;
  assign sense.reached = (count_reg == short_limit);
  count_step_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    ce && sense.trip && !sense.clear && count_reg != short_limit
    |=> count_reg == $past(count_reg) + count_one)
    else $error("counter did not step on trip");
endmodule // short_event_counter

// ==== tb/host_model.sv ====
// host_model: system host that programs the option word and plugs adapter
// assumes the bench hands it requests on the core clock
`timescale 1ns/100ps
module host_model (
  input wire logic clk, // core clock
  input wire logic arst_n, // async reset, active low
  input wire logic [15:0] opt_req, // option word the host wants
  input wire logic plug_req, // adapter plugged in
  output logic [15:0] charger_option_word, // option word to device
  output logic adapter_present // adapter detect level
);
  // host writes its whole option word after each request
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      charger_option_word <= 16'h0000;
      adapter_present <= 1'b1;
    end else begin
      charger_option_word <= opt_req;
      adapter_present <= plug_req;
    end
  end
endmodule // host_model

// ==== tb/short_latch_top_tb.sv ====
// short_latch_top_tb: scenario bench for the short latch block
// assumes host_model stands in for the option word and adapter pin
`timescale 1ns/100ps
module short_latch_top_tb;
  logic clk = 0, arst_n = 0, hi_e = 0, lo_e = 0, neg = 0, plug = 1;
  logic nsync = 0, at_lim = 0, lg_req = 1, sw_en, lg, lat, ce = 1;
  logic [15:0] opt = 16'h0000, optw;
  logic [11:0] pos = 0, ph = 0, batt = 0, req = 0, lim, a;
  logic present;
  int n_mismatch = 0, num_checks = 0;
  host_model i_host_model (.clk(clk), .arst_n(arst_n), .opt_req(opt),
    .plug_req(plug), .charger_option_word(optw), .adapter_present(present));
  short_latch_top i_short_latch_top (.clk(clk), .arst_n(arst_n), .ce(ce),
    .charger_option_word(optw), .high_edge(hi_e), .low_edge(lo_e),
    .adapter_sense_pos(pos), .phase_mv(ph), .phase_neg(neg),
    .adapter_present(present), .nonsync_mode(nsync), .batt_mv(batt),
    .input_at_limit(at_lim), .charge_req_ma(req), .low_gate_req(lg_req),
    .switching_en(sw_en), .low_gate(lg), .charge_lim_ma(lim),
    .latched_off(lat));
  // clock generator
  always #50 clk = ~clk;
  // compare one value
  task automatic chk(input string nm, input logic [11:0] s, e);
    num_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // n switch edges, each given time to be sampled and counted
  task automatic pulse(input logic hs, input int n);
    repeat (n) begin
      @(posedge clk);
      if (hs) hi_e <= 1'b1;
      else lo_e <= 1'b1;
      @(posedge clk);
      hi_e <= 1'b0;
      lo_e <= 1'b0;
      cyc(5);
    end
  endtask
  // adapter out and back in
  task automatic replug;
    @(posedge clk);
    plug <= 1'b0;
    cyc(5);
    plug <= 1'b1;
    cyc(8);
    chk("latched_off", 12'(lat), 12'h000);
  endtask
  task automatic check_latched;
    chk("latched_off", 12'(lat), 12'h001);
    cyc(30);
    chk("latched_off", 12'(lat), 12'h001);
    chk("switching_en", 12'(sw_en), 12'h000);
    chk("low_gate", 12'(lg), 12'h000);
  endtask
  // low side threshold by option bit 7
  task automatic low_case(input logic sel, input logic [11:0] thr);
    @(posedge clk);
    opt <= {8'h00, sel, 7'h00};
    neg <= 1'b1;
    ph <= thr + 12'h0064;
    pulse(0, 7);
    chk("latched_off", 12'(lat), 12'h000);
    neg <= 1'b0;
    ph <= thr - 12'h0001;
    pulse(0, 7);
    chk("latched_off", 12'(lat), 12'h000);
    ph <= thr;
    cyc(50);
    chk("latched_off", 12'(lat), 12'h000);
    pulse(0, 6);
    chk("latched_off", 12'(lat), 12'h000);
    pulse(0, 1);
    check_latched();
    replug();
    neg <= 1'b0;
  endtask
  // high side check, disabled then enabled by option bit 8
  task automatic high_case;
    @(posedge clk);
    opt <= 16'h0000;
    pos <= 12'h0400;
    ph <= 12'h00e0;
    pulse(1, 7);
    chk("latched_off", 12'(lat), 12'h000);
    opt <= 16'h0100;
    ph <= 12'h0113;
    pulse(1, 7);
    chk("latched_off", 12'(lat), 12'h000);
    ph <= 12'h0112;
    pulse(1, 7);
    check_latched();
    replug();
  endtask
  // non-sync gate, current caps and input limit throttling
  task automatic current_case;
    @(posedge clk);
    nsync <= 1'b1;
    req <= 12'h03e8;
    batt <= 12'h0bb8;
    cyc(8);
    chk("low_gate", 12'(lg), 12'h000);
    chk("charge_lim_ma", lim, 12'h00fa);
    batt <= 12'h07d0;
    cyc(8);
    chk("charge_lim_ma", lim, 12'h01f4);
    req <= 12'h0064;
    cyc(8);
    chk("charge_lim_ma", lim, 12'h0064);
    nsync <= 1'b0;
    req <= 12'h03e8;
    cyc(8);
    chk("low_gate", 12'(lg), 12'h001);
    chk("charge_lim_ma", lim, 12'h03e8);
    at_lim <= 1'b1;
    cyc(20);
    a = lim;
    cyc(10);
    chk("charge_lim_ma", a, 12'h03d7);
    chk("charge_lim_ma", lim, 12'h03cd);
    // clock enable low freezes the throttled limit
    ce <= 1'b0;
    cyc(5);
    chk("charge_lim_ma", lim, 12'h03cc);
    ce <= 1'b1;
    at_lim <= 1'b0;
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // watchdog
  initial begin
    #3_000_000;
    n_mismatch++;
    report_and_stop();
  end
  // main sequence
  initial begin
    cyc(4);
    arst_n <= 1'b1;
    cyc(2);
    low_case(1'b0, 12'h0087);
    low_case(1'b1, 12'h00e6);
    high_case();
    current_case();
    report_and_stop();
  end
endmodule // short_latch_top_tb
